// file: vpic_top.sv
// Decided for this implementation: the plain strobed port and the placing of the registers.
`default_nettype none
// Vectored priority interrupt controller
module vpic_top
    import vpic_pkg::*;
(
    input  wire logic                     sys_clk_i,
    input  wire logic                     rst_n_i,
    input  wire logic                     standby_n_i,
    input  wire logic                     adv_mode_i,
    input  wire logic [3:0]               addr_i,
    input  wire logic [7:0]               wdata_i,
    input  wire logic                     wr_i,
    input  wire logic                     rd_i,
    output logic      [7:0]               rdata_o,
    input  wire logic                     nmi_pin_i,
    input  wire logic [7:0]               pin_req_i,
    input  wire logic [VPIC_NUM_INT-1:0]  per_flag_i,
    input  wire logic [VPIC_NUM_INT-1:0]  per_ena_i,
    input  wire logic                     user_mask_bit_i,
    input  wire logic [2:0]               mask_level_bits_i,
    input  wire logic                     ack_i,
    input  wire logic                     xfer_start_i,
    output logic                          irq_o,
    output logic [6:0]                    vec_num_o,
    output logic [15:0]                   vec_addr_o,
    output logic [2:0]                    vec_lvl_o,
    output logic                          xfer_irq_o
);
    typedef struct packed {
        logic [VPIC_NUM_PRI-1:0][7:0] pri;
        logic [7:0]  sys;
        logic [7:0]  ena;
        logic        nmi_d;
        logic        nmi_pend;
        logic [7:0]  rdata;
        logic        irq;
        logic [6:0]  vec;
        logic [15:0] addr;
        logic [2:0]  lvl;
        logic        xfer;
    } vpic_state_t;

    vpic_state_t st_reg;
    vpic_state_t st_next;

    logic [75:0]     slot_req;
    logic [76*3-1:0] slot_lvl;
    logic            found;
    logic [6:0]      win_vec;
    logic [2:0]      win_lvl;
    vpic_mode_t      mode;
    logic            nmi_edge;
    logic            pass;

    vpic_src_map u_map (
        .pin_req_i  (pin_req_i),
        .pin_ena_i  (st_reg.ena),
        .per_flag_i (per_flag_i),
        .per_ena_i  (per_ena_i),
        .slot_req_o (slot_req)
    );

    // Level of every slot from its priority field
    always_comb begin
        logic [4:0] f;
        f = 5'h00;
        slot_lvl = '0;
        for (int s = 0; s < 76; s++) begin
            f = vpic_field_of(7'(s + 16));
            slot_lvl[s*3 +: 3] = f[0] ? st_reg.pri[f[4:1]][6:4]
                                      : st_reg.pri[f[4:1]][2:0];
        end
    end

    vpic_arbiter u_arb (
        .slot_req_i (slot_req),
        .slot_lvl_i (slot_lvl),
        .found_o    (found),
        .vec_o      (win_vec),
        .lvl_o      (win_lvl)
    );

    assign mode = vpic_mode_t'({st_reg.sys[VPIC_SYS_MHI], st_reg.sys[VPIC_SYS_MLO]});
    // Edge select: 0 falling, 1 rising
    assign nmi_edge = st_reg.sys[VPIC_SYS_EDGE] ? (nmi_pin_i && !st_reg.nmi_d)
                                               : (!nmi_pin_i && st_reg.nmi_d);
    // Acceptance control and eight-level masking
    always_comb begin
        pass = 1'b0;
        if (mode == VPIC_MODE2) begin
            pass = found && (win_lvl > mask_level_bits_i);
        end else begin
            pass = found && !user_mask_bit_i;
        end
    end

    // Next state of registers and outputs
    always_comb begin
        st_next       = st_reg;
        st_next.nmi_d = nmi_pin_i;
        st_next.rdata = 8'h00;
        if (wr_i) begin
            if (addr_i < 4'(VPIC_NUM_PRI)) begin
                st_next.pri[addr_i] = (wdata_i & 8'h77) |
                    ((addr_i == VPIC_PRI_D) ? 8'h07 : 8'h00) |
                    ((addr_i == VPIC_PRI_E || addr_i == VPIC_PRI_J) ? 8'h70 : 8'h00);
            end else if (addr_i == VPIC_OFS_SYS) begin
                // Prohibited mode codes are not accepted
                if (!wdata_i[VPIC_SYS_MLO]) begin
                    st_next.sys = wdata_i;
                end
            end else if (addr_i == VPIC_OFS_ENA) begin
                st_next.ena = wdata_i;
            end
        end
        if (rd_i) begin
            unique case (addr_i) inside
                [VPIC_OFS_PRI0:VPIC_PRI_K]: st_next.rdata = st_reg.pri[addr_i];
                VPIC_OFS_SYS:  st_next.rdata = st_reg.sys;
                VPIC_OFS_ENA:  st_next.rdata = st_reg.ena;
                VPIC_OFS_STAT: st_next.rdata = {5'h00, st_reg.nmi_pend, st_reg.xfer, st_reg.irq};
                VPIC_OFS_VEC:  st_next.rdata = {1'b0, st_reg.vec};
                default:       st_next.rdata = 8'h00;
            endcase
        end
        // Non-maskable latch, set wins over acknowledge
        if (ack_i) begin
            st_next.nmi_pend = 1'b0;
        end
        if (nmi_edge) begin
            st_next.nmi_pend = 1'b1;
        end
        st_next.xfer = 1'b0;
        if (st_next.nmi_pend) begin
            st_next.irq = 1'b1;
            st_next.vec = VPIC_VEC_NMI;
            st_next.lvl = 3'h7;
        end else if (pass && vpic_slot_valid(win_vec)) begin
            st_next.irq = !xfer_start_i;
            st_next.xfer = xfer_start_i;
            st_next.vec = win_vec;
            st_next.lvl = win_lvl;
        end else begin
            st_next.irq = 1'b0;
        end
        st_next.addr = vpic_vec_addr(st_next.vec, adv_mode_i);
    end

    // State register; reset and hardware standby both initialise
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i || !standby_n_i) begin
            for (int i = 0; i < VPIC_NUM_PRI; i++) begin
                st_reg.pri[i] <= VPIC_PRI_RESET;
            end
            st_reg.sys      <= VPIC_SYS_RESET;
            st_reg.ena      <= VPIC_ENA_RESET;
            st_reg.nmi_d    <= 1'b0;
            st_reg.nmi_pend <= 1'b0;
            st_reg.rdata    <= 8'h00;
            st_reg.irq      <= 1'b0;
            st_reg.vec      <= 7'h00;
            st_reg.addr     <= 16'h0000;
            st_reg.lvl      <= 3'h0;
            st_reg.xfer     <= 1'b0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign rdata_o    = st_reg.rdata;
    assign irq_o      = st_reg.irq;
    assign vec_num_o  = st_reg.vec;
    assign vec_addr_o = st_reg.addr;
    assign vec_lvl_o  = st_reg.lvl;
    assign xfer_irq_o = st_reg.xfer;
endmodule
`default_nettype wire

// file: vpic_pkg.sv
`default_nettype none
package vpic_pkg;
    localparam int          VPIC_NUM_INT    = 47;
    localparam int          VPIC_NUM_PIN    = 8;
    localparam int          VPIC_NUM_SRC    = 76;   // Vector slots 16 to 91
    localparam int          VPIC_NUM_PRI    = 11;
    localparam logic [6:0]  VPIC_VEC_NMI    = 7'h07;
    localparam logic [6:0]  VPIC_VEC_PIN0   = 7'h10;
    localparam logic [7:0]  VPIC_PRI_RESET  = 8'h77;
    localparam logic [7:0]  VPIC_PRI_RSVD   = 8'h77;
    localparam logic [7:0]  VPIC_SYS_RESET  = 8'h01;
    localparam int          VPIC_SYS_EDGE   = 3;
    localparam int          VPIC_SYS_MLO    = 4;
    localparam int          VPIC_SYS_MHI    = 5;
    localparam logic [7:0]  VPIC_ENA_RESET  = 8'h00;
    // Register offsets of the plain register port
    localparam logic [3:0]  VPIC_OFS_PRI0   = 4'h0;
    localparam logic [3:0]  VPIC_OFS_SYS    = 4'hB;
    localparam logic [3:0]  VPIC_OFS_ENA    = 4'hC;
    localparam logic [3:0]  VPIC_OFS_STAT   = 4'hD;
    localparam logic [3:0]  VPIC_OFS_VEC    = 4'hE;
    // Field selectors: register index and high half flag
    localparam logic [3:0]  VPIC_PRI_A = 4'h0;
    localparam logic [3:0]  VPIC_PRI_B = 4'h1;
    localparam logic [3:0]  VPIC_PRI_C = 4'h2;
    localparam logic [3:0]  VPIC_PRI_D = 4'h3;
    localparam logic [3:0]  VPIC_PRI_E = 4'h4;
    localparam logic [3:0]  VPIC_PRI_F = 4'h5;
    localparam logic [3:0]  VPIC_PRI_G = 4'h6;
    localparam logic [3:0]  VPIC_PRI_H = 4'h7;
    localparam logic [3:0]  VPIC_PRI_I = 4'h8;
    localparam logic [3:0]  VPIC_PRI_J = 4'h9;
    localparam logic [3:0]  VPIC_PRI_K = 4'hA;

    typedef enum logic [1:0] {
        VPIC_MODE0 = 2'b00,
        VPIC_MODE2 = 2'b10
    } vpic_mode_t;

    // Source slot s holds vector 16+s; table of valid vectors and their level field
    function automatic logic vpic_slot_valid(input logic [6:0] vec);
        vpic_slot_valid = !((vec >= 7'd26 && vec <= 7'd27) || (vec >= 7'd29 && vec <= 7'd31) ||
                            (vec >= 7'd37 && vec <= 7'd39) || (vec >= 7'd53 && vec <= 7'd55) ||
                            (vec == 7'd67) || (vec >= 7'd71 && vec <= 7'd79));
    endfunction

    // Returns {register index, high half} for a valid vector
    function automatic logic [4:0] vpic_field_of(input logic [6:0] vec);
        logic [4:0] f;
        f = {VPIC_PRI_A, 1'b1};
        if      (vec == 7'd16)                 f = {VPIC_PRI_A, 1'b1};
        else if (vec == 7'd17)                 f = {VPIC_PRI_A, 1'b0};
        else if (vec <= 7'd19)                 f = {VPIC_PRI_B, 1'b1};
        else if (vec <= 7'd21)                 f = {VPIC_PRI_B, 1'b0};
        else if (vec <= 7'd23)                 f = {VPIC_PRI_C, 1'b1};
        else if (vec == 7'd24)                 f = {VPIC_PRI_C, 1'b0};
        else if (vec == 7'd25)                 f = {VPIC_PRI_D, 1'b1};
        else if (vec == 7'd28)                 f = {VPIC_PRI_E, 1'b0};
        else if (vec <= 7'd39)                 f = {VPIC_PRI_F, 1'b1};
        else if (vec <= 7'd43)                 f = {VPIC_PRI_F, 1'b0};
        else if (vec <= 7'd47)                 f = {VPIC_PRI_G, 1'b1};
        else if (vec <= 7'd55)                 f = {VPIC_PRI_G, 1'b0};
        else if (vec <= 7'd59)                 f = {VPIC_PRI_H, 1'b1};
        else if (vec <= 7'd63)                 f = {VPIC_PRI_H, 1'b0};
        else if (vec <= 7'd67)                 f = {VPIC_PRI_I, 1'b1};
        else if (vec <= 7'd79)                 f = {VPIC_PRI_I, 1'b0};
        else if (vec <= 7'd83)                 f = {VPIC_PRI_J, 1'b0};
        else if (vec <= 7'd87)                 f = {VPIC_PRI_K, 1'b1};
        else                                   f = {VPIC_PRI_K, 1'b0};
        vpic_field_of = f;
    endfunction

    // Vector address from vector number and address mode
    function automatic logic [15:0] vpic_vec_addr(input logic [6:0] vec, input logic adv);
        vpic_vec_addr = adv ? {7'h00, vec, 2'b00} : {8'h00, vec, 1'b0};
    endfunction
endpackage
`default_nettype wire

// file: vpic_src_map.sv
`default_nettype none
// Packs the pin and 47 peripheral requests into vector-ordered slots
module vpic_src_map
    import vpic_pkg::*;
(
    input  wire logic [7:0]                pin_req_i,
    input  wire logic [7:0]                pin_ena_i,
    input  wire logic [VPIC_NUM_INT-1:0]   per_flag_i,
    input  wire logic [VPIC_NUM_INT-1:0]   per_ena_i,
    output logic      [VPIC_NUM_SRC-1:0]   slot_req_o
);
    logic [VPIC_NUM_INT-1:0] per_req;
    // Peripheral request only while flag and enable are both set
    assign per_req = per_flag_i & per_ena_i;

    // Place the 47 peripheral requests into valid slots in vector order
    always_comb begin
        int k;
        k = 0;
        slot_req_o = '0;
        slot_req_o[7:0] = pin_req_i & pin_ena_i;
        for (int s = 8; s < VPIC_NUM_SRC; s++) begin
            if (vpic_slot_valid(7'(s + 16)) && k < VPIC_NUM_INT) begin
                slot_req_o[s] = per_req[k];
                k = k + 1;
            end
        end
    end
endmodule
`default_nettype wire

// file: vpic_arbiter.sv
`default_nettype none
// Picks the highest level; ties go to the smaller vector number
module vpic_arbiter
    import vpic_pkg::*;
(
    input  wire logic [76*1-1:0]      slot_req_i,
    input  wire logic [76*3-1:0]      slot_lvl_i,
    output logic                      found_o,
    output logic [6:0]                vec_o,
    output logic [2:0]                lvl_o
);
    // Scan downwards so the lowest vector wins among equal levels
    always_comb begin
        found_o = 1'b0;
        vec_o   = 7'h00;
        lvl_o   = 3'h0;
        for (int s = 75; s >= 0; s--) begin
            if (slot_req_i[s] && (!found_o || slot_lvl_i[s*3 +: 3] >= lvl_o)) begin
                found_o = 1'b1;
                vec_o   = 7'(s + 16);
                lvl_o   = slot_lvl_i[s*3 +: 3];
            end
        end
    end
endmodule
`default_nettype wire

// file: vpic_chk_sva.sv
`default_nettype none
// Port checker for the interrupt controller
module vpic_chk
    import vpic_pkg::*;
(
    input wire logic        sys_clk_i,
    input wire logic        rst_n_i,
    input wire logic        standby_n_i,
    input wire logic        adv_mode_i,
    input wire logic [3:0]  addr_i,
    input wire logic [7:0]  wdata_i,
    input wire logic        wr_i,
    input wire logic        rd_i,
    input wire logic [7:0]  rdata_o,
    input wire logic        nmi_pin_i,
    input wire logic [7:0]  pin_req_i,
    input wire logic [46:0] per_flag_i,
    input wire logic [46:0] per_ena_i,
    input wire logic        user_mask_bit_i,
    input wire logic [2:0]  mask_level_bits_i,
    input wire logic        irq_o,
    input wire logic [6:0]  vec_num_o,
    input wire logic [15:0] vec_addr_o,
    input wire logic [2:0]  vec_lvl_o,
    input wire logic        xfer_irq_o
);
    logic mode_reg;
    logic edge_reg;
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);
    // Shadow of the mode and edge bits
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i || !standby_n_i) begin
            mode_reg <= 1'b0;
            edge_reg <= 1'b0;
        end else if (wr_i && addr_i == VPIC_OFS_SYS && !wdata_i[VPIC_SYS_MLO]) begin
            mode_reg <= wdata_i[VPIC_SYS_MHI];
            edge_reg <= wdata_i[VPIC_SYS_EDGE];
        end
    end
    a_addr_map: assert property (irq_o && adv_mode_i == $past(adv_mode_i) |->
        vec_addr_o == (adv_mode_i ? {7'h00, vec_num_o, 2'b00} : {8'h00, vec_num_o, 1'b0}))
        else $error("vector address mismatch");
    a_no_reserved: assert property (irq_o |-> !(vec_num_o inside {[0:6], [8:15],
        26, 27, [29:31], [37:39], [53:55], 67, [71:79], [92:127]}))
        else $error("reserved vector issued");
    a_standby_quiet: assert property (!standby_n_i |=> !irq_o && !xfer_irq_o)
        else $error("request during standby");
    a_mode0_mask: assert property (irq_o && !$past(mode_reg) && $past(user_mask_bit_i)
        |-> vec_num_o == VPIC_VEC_NMI) else $error("masked request passed");
    a_level_gate: assert property (irq_o && $past(mode_reg) && vec_num_o != VPIC_VEC_NMI
        |-> vec_lvl_o > $past(mask_level_bits_i)) else $error("level not above mask");
    a_per_gate: assert property (irq_o && vec_num_o >= 7'h18 |->
        ($past(per_flag_i) & $past(per_ena_i)) != '0) else $error("ungated source");
    a_pin_source: assert property (irq_o && vec_num_o inside {[16:23]} |->
        (($past(pin_req_i) >> vec_num_o[2:0]) & 8'h01) != 8'h00) else $error("pin vector");
    a_nmi_taken: assert property (standby_n_i &&
        (edge_reg ? $rose(nmi_pin_i) : $fell(nmi_pin_i))
        |-> ##[1:3] (irq_o && vec_num_o == VPIC_VEC_NMI)) else $error("nmi not taken");
    a_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
        else $error("read data outside slot");
    c_nmi: cover property (irq_o && vec_num_o == VPIC_VEC_NMI);
    c_mode2: cover property (irq_o && mode_reg);
    c_xfer: cover property (xfer_irq_o);
endmodule
bind vpic_top vpic_chk u_chk (.*);
`default_nettype wire

// file: vpic_cpu_model.sv
`default_nettype none
// Peripheral flags and core acknowledge
module vpic_cpu_model
    import vpic_pkg::*;
(
    input  wire logic                    sys_clk_i,
    input  wire logic [5:0]              sel_i,
    input  wire logic                    flag_on_i,
    input  wire logic                    ena_on_i,
    input  wire logic                    irq_i,
    input  wire logic [6:0]              vec_num_i,
    output logic      [VPIC_NUM_INT-1:0] per_flag_o,
    output logic      [VPIC_NUM_INT-1:0] per_ena_o,
    output var logic                     ack_o
);
    // One selected source with its flag and enable
    assign per_flag_o = flag_on_i ? (VPIC_NUM_INT'(1) << sel_i) : '0;
    assign per_ena_o  = ena_on_i ? (VPIC_NUM_INT'(1) << sel_i) : '0;
    // Core accepts the non-maskable entry at once
    initial ack_o = 1'b0;
    always @(posedge sys_clk_i) begin
        ack_o <= irq_i && vec_num_i == VPIC_VEC_NMI && !ack_o;
    end
endmodule
`default_nettype wire

// file: tb_vectored_priority_interrupt_ctrl.sv
`default_nettype none
module tb_vectored_priority_interrupt_ctrl
    import vpic_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [5:0] idx; logic [6:0] vec; logic adv;} vpic_row_t;
    vpic_row_t rows [13] = '{'{6'h00, 7'h18, 1'b0}, '{6'h01, 7'h19, 1'b1},
        '{6'h02, 7'h1C, 1'b0}, '{6'h03, 7'h20, 1'b1}, '{6'h07, 7'h24, 1'b0},
        '{6'h08, 7'h28, 1'b1}, '{6'h14, 7'h34, 1'b0}, '{6'h15, 7'h38, 1'b1},
        '{6'h1F, 7'h42, 1'b0}, '{6'h20, 7'h44, 1'b1}, '{6'h22, 7'h46, 1'b0},
        '{6'h23, 7'h50, 1'b1}, '{6'h2E, 7'h5B, 1'b0}};
    logic        sys_clk_i = 1'b0;
    logic        rst_n_i, standby_n_i, adv_mode_i, wr_i, rd_i, nmi_pin_i;
    logic        user_mask_bit_i, ack_i, xfer_start_i, irq_o, xfer_irq_o;
    logic        flag_on, ena_on;
    logic [3:0]  addr_i;
    logic [7:0]  wdata_i, rdata_o, pin_req_i, q;
    logic [2:0]  mask_level_bits_i, vec_lvl_o;
    logic [5:0]  sel;
    logic [6:0]  vec_num_o;
    logic [15:0] vec_addr_o;
    logic [VPIC_NUM_INT-1:0] per_flag_i, per_ena_i;
    int          checks, fails, cyc;

    vpic_top uut (
        .sys_clk_i         (sys_clk_i),
        .rst_n_i           (rst_n_i),
        .standby_n_i       (standby_n_i),
        .adv_mode_i        (adv_mode_i),
        .addr_i            (addr_i),
        .wdata_i           (wdata_i),
        .wr_i              (wr_i),
        .rd_i              (rd_i),
        .rdata_o           (rdata_o),
        .nmi_pin_i         (nmi_pin_i),
        .pin_req_i         (pin_req_i),
        .per_flag_i        (per_flag_i),
        .per_ena_i         (per_ena_i),
        .user_mask_bit_i   (user_mask_bit_i),
        .mask_level_bits_i (mask_level_bits_i),
        .ack_i             (ack_i),
        .xfer_start_i      (xfer_start_i),
        .irq_o             (irq_o),
        .vec_num_o         (vec_num_o),
        .vec_addr_o        (vec_addr_o),
        .vec_lvl_o         (vec_lvl_o),
        .xfer_irq_o        (xfer_irq_o)
    );
    vpic_cpu_model peer (
        .sys_clk_i  (sys_clk_i),
        .sel_i      (sel),
        .flag_on_i  (flag_on),
        .ena_on_i   (ena_on),
        .irq_i      (irq_o),
        .vec_num_i  (vec_num_o),
        .per_flag_o (per_flag_i),
        .per_ena_o  (per_ena_i),
        .ack_o      (ack_i)
    );
    // Clock and hang guard
    always #25 sys_clk_i = ~sys_clk_i;
    always @(posedge sys_clk_i) begin
        cyc++;
        if (cyc > 3000) begin
            fails++;
            conclude();
        end
    end
    task automatic conclude();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic tick();
        @(posedge sys_clk_i);
        #1;
    endtask
    task automatic wait_irq(input logic lvl);
        for (int n = 0; n < 6 && irq_o !== lvl; n++)
            tick();
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge sys_clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge sys_clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge sys_clk_i);
        rd_i <= 1'b0;
        #1;
        chk(rdata_o, exp, "register read");
    endtask
    // Main sequence
    initial begin
        {rst_n_i, adv_mode_i, wr_i, rd_i, user_mask_bit_i, xfer_start_i} = 6'h00;
        {flag_on, ena_on, standby_n_i, nmi_pin_i} = 4'h3;
        {addr_i, wdata_i, pin_req_i, mask_level_bits_i, sel} = 29'h0000000;
        repeat (2) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        tick();
        chk(irq_o, 1'b0, "irq after reset");
        rd(VPIC_OFS_PRI0, 8'h77);
        rd(VPIC_OFS_SYS, 8'h01);
        rd(VPIC_OFS_ENA, 8'h00);
        rd(4'hF, 8'h00);
        foreach (rows[i]) begin
            @(posedge sys_clk_i);
            adv_mode_i <= rows[i].adv;
            sel <= rows[i].idx;
            {flag_on, ena_on} <= 2'b11;
            tick();
            chk({irq_o, vec_num_o}, {1'b1, rows[i].vec}, "vector");
            chk(vec_addr_o, rows[i].adv ? {rows[i].vec, 2'b00} : {rows[i].vec, 1'b0},
                "address");
            @(posedge sys_clk_i);
            {flag_on, ena_on} <= 2'b00;
            tick();
        end
        @(posedge sys_clk_i);
        {sel, flag_on, pin_req_i} <= {6'h00, 1'b1, 8'h01};
        tick();
        chk(irq_o, 1'b0, "gated source");
        wr(VPIC_OFS_ENA, 8'h01);
        tick();
        chk(vec_num_o, 7'h10, "pin vector");
        @(posedge sys_clk_i);
        ena_on <= 1'b1;
        tick();
        chk(vec_num_o, 7'h10, "default order");
        @(posedge sys_clk_i);
        user_mask_bit_i <= 1'b1;
        tick();
        chk(irq_o, 1'b0, "global mask");
        @(posedge sys_clk_i);
        nmi_pin_i <= 1'b0;
        wait_irq(1'b1);
        chk(vec_num_o, 7'h07, "nmi vector");
        chk(vec_addr_o, 16'h000E, "nmi address");
        wait_irq(1'b0);
        chk(irq_o, 1'b0, "nmi cleared");
        wr(VPIC_OFS_SYS, 8'h20);
        wr(VPIC_OFS_PRI0, 8'h17);
        tick();
        chk({vec_num_o, vec_lvl_o}, {7'h18, 3'h7}, "level winner");
        @(posedge sys_clk_i);
        {flag_on, mask_level_bits_i} <= {1'b0, 3'h1};
        tick();
        chk(irq_o, 1'b0, "level at mask");
        @(posedge sys_clk_i);
        mask_level_bits_i <= 3'h0;
        tick();
        chk({vec_num_o, vec_lvl_o}, {7'h10, 3'h1}, "level above mask");
        @(posedge sys_clk_i);
        xfer_start_i <= 1'b1;
        tick();
        chk(xfer_irq_o, 1'b1, "transfer start");
        @(posedge sys_clk_i);
        {xfer_start_i, pin_req_i} <= {1'b0, 8'h00};
        wr(VPIC_OFS_SYS, 8'h10);
        rd(VPIC_OFS_SYS, 8'h20);
        // Rising edge select, then raise the non-maskable pin
        wr(VPIC_OFS_SYS, 8'h28);
        @(posedge sys_clk_i);
        nmi_pin_i <= 1'b1;
        wait_irq(1'b1);
        chk(vec_num_o, 7'h07, "rising nmi");
        wait_irq(1'b0);
        chk(irq_o, 1'b0, "rising nmi cleared");
        // Standby with a live pin request and a falling pin
        @(posedge sys_clk_i);
        {standby_n_i, nmi_pin_i, pin_req_i} <= {2'b00, 8'h01};
        tick();
        chk(irq_o, 1'b0, "standby");
        @(posedge sys_clk_i);
        standby_n_i <= 1'b1;
        rd(VPIC_OFS_SYS, 8'h01);
        chk(irq_o, 1'b0, "no edge in standby");
        conclude();
    end
endmodule
`default_nettype wire
